/* hw/ftx_framer.sv */
// Transmit framer: register file, packet memory fetch, frame serializer,
// raw serial-port streaming and amplifier level sequencing.
// Assumes a packet memory on the same clock answering a read one cycle later,
// and a bit period of at least four clock cycles.
//
// Notes on behaviour
// - Operating select 4 starts packet framing.
// - Payload fetch starts at transmit base pointer.
// - Preamble is repeated 0xAA bytes, programmable.
// - Preamble bytes equal lead-in plus validation counts.
// - Sync sent MSB first, high byte first.
// - Sync always whole bytes; host pads.
// - Length counts bytes from sync to CRC.
// - CRC-16 with polynomial x16+x12+x5+1 appended.
// - Checksum-disable bit suppresses CRC; resets to zero.
// - Two 0xAA postamble bytes follow the CRC.
// - Ramp-down runs during second postamble byte.
// - Host stores length, payload; framer adds rest.
// - Operating select 3 starts raw serial transmit.
// - Serial mode streams input until leave command.
// - Serial mode raises no frame event pulses.
// - Serial mode runs the same calibration first.
// - Serial latency two bits shaped, half unshaped.
// - Amplifier level follows the power field.
// - Bias 63 and bridge 21 give high power.
// - After frame, amplifier off, packet-sent pulse.
// - Ramp amplifier up before frame starts.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module ftx_framer #(
  parameter int BIT_DIV = 16,
  parameter int CAL_CYCLES = 64,
  parameter int RAMP_DIV = 8,
  parameter int PWR_W = 5,
  parameter logic [15:0] CRC_INIT = 16'h0000
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [9:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] pkt_mem_addr_o,
  output logic pkt_mem_rd_o,
  input wire logic [7:0] pkt_mem_rdata_i,
  input wire logic raw_serial_port_data_i,
  output logic tx_data_o,
  output logic tx_bit_strobe_o,
  output logic tx_active_o,
  output logic amp_on_o,
  output logic [PWR_W-1:0] amp_level_o,
  output logic [5:0] amp_bias_control_o,
  output logic [4:0] bridge_bias_setting_o,
  output logic amp_high_power_o,
  output logic sfd_sent_o,
  output logic pkt_sent_o
);

  //////////////////////////////////////////////////////////////////////////////
  // CRC-16 over one byte, most significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ ftx_pkg::CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] preamble_byte_count_r;
  logic [7:0] validation_preamble_count_r;
  logic [7:0] sync_pattern_low_byte_r;
  logic [7:0] sync_pattern_mid_byte_r;
  logic [7:0] sync_pattern_high_byte_r;
  logic [7:0] operating_select_r;
  logic [7:0] transmit_base_pointer_r;
  logic [1:0] pkt_cfg_r;
  logic [PWR_W-1:0] amplifier_power_level_r;
  logic [5:0] amp_bias_r;
  logic [4:0] bridge_r;
  logic sfd_flag_r;
  logic sent_flag_r;

  ftx_pkg::ftx_state_e st_r, st_nxt;
  logic [8:0] byte_cnt_r, byte_cnt_nxt;
  logic [15:0] crc_r;
  logic [7:0] shift_r, ld_byte;
  logic [2:0] bit_cnt_r;
  logic [15:0] div_r;
  logic bit_en, half_en;
  logic [15:0] tmr_r;
  logic [15:0] ramp_div_r;
  logic ramp_tick;
  logic [7:0] addr_r, mem_byte_r;
  logic rd_pend_r;
  logic ld, fetch, crc_upd, sfd_evt, sent_evt;
  logic stream_r;
  logic sp_s1_r, sp_s2_r, sp_d0_r, sp_d1_r;
  logic [8:0] pre_total;

  logic wr_cmd, start_cmd, leave_cmd, wr_status;
  logic framing, byte_end;

  assign wr_cmd = reg_wr_i && (reg_addr_i == ftx_pkg::ADDR_COMMAND);
  assign start_cmd = wr_cmd && (reg_wdata_i == ftx_pkg::CMD_ENTER_TX);
  assign leave_cmd = wr_cmd && (reg_wdata_i == ftx_pkg::CMD_LEAVE_TX);
  assign wr_status = reg_wr_i && (reg_addr_i == ftx_pkg::ADDR_STATUS);
  // Preamble byte total from both counts
  assign pre_total = {1'b0, preamble_byte_count_r} + {1'b0, validation_preamble_count_r};

  //////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      preamble_byte_count_r <= ftx_pkg::RST_PREAMBLE_BYTE_COUNT;
      validation_preamble_count_r <= ftx_pkg::RST_VALIDATION_PREAMBLE_COUNT;
      sync_pattern_low_byte_r <= ftx_pkg::RST_SYNC_BYTE;
      sync_pattern_mid_byte_r <= ftx_pkg::RST_SYNC_BYTE;
      sync_pattern_high_byte_r <= ftx_pkg::RST_SYNC_BYTE;
      operating_select_r <= ftx_pkg::RST_RADIO_CONFIGURATION;
      transmit_base_pointer_r <= ftx_pkg::RST_TRANSMIT_BASE_POINTER;
      pkt_cfg_r <= ftx_pkg::RST_PKT_CFG;
      amplifier_power_level_r <= '0;
      amp_bias_r <= ftx_pkg::RST_AMP_BIAS_CONTROL;
      bridge_r <= ftx_pkg::RST_BRIDGE_BIAS_SETTING;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ftx_pkg::ADDR_PREAMBLE_BYTE_COUNT) begin
        preamble_byte_count_r <= reg_wdata_i;
      end else if (reg_addr_i == ftx_pkg::ADDR_VALIDATION_PREAMBLE_COUNT) begin
        validation_preamble_count_r <= reg_wdata_i;
      end else if (reg_addr_i == ftx_pkg::ADDR_SYNC_PATTERN_LOW_BYTE) begin
        sync_pattern_low_byte_r <= reg_wdata_i;
      end else if (reg_addr_i == ftx_pkg::ADDR_SYNC_PATTERN_MID_BYTE) begin
        sync_pattern_mid_byte_r <= reg_wdata_i;
      end else if (reg_addr_i == ftx_pkg::ADDR_SYNC_PATTERN_HIGH_BYTE) begin
        sync_pattern_high_byte_r <= reg_wdata_i;
      end else if (reg_addr_i == ftx_pkg::ADDR_RADIO_CONFIGURATION) begin
        operating_select_r <= reg_wdata_i;
      end else if (reg_addr_i == ftx_pkg::ADDR_TRANSMIT_BASE_POINTER) begin
        transmit_base_pointer_r <= reg_wdata_i;
      end else if (reg_addr_i == ftx_pkg::ADDR_PKT_CFG) begin
        pkt_cfg_r <= reg_wdata_i[1:0];
      end else if (reg_addr_i == ftx_pkg::ADDR_AMP_POWER_LEVEL) begin
        amplifier_power_level_r <= reg_wdata_i[PWR_W-1:0];
      end else if (reg_addr_i == ftx_pkg::ADDR_AMP_BIAS_REGISTER) begin
        amp_bias_r <= reg_wdata_i[5:0];
      end else if (reg_addr_i == ftx_pkg::ADDR_AMP_CONFIG_REGISTER) begin
        bridge_r <= reg_wdata_i[4:0];
      end
    end
  end

  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == ftx_pkg::ADDR_PREAMBLE_BYTE_COUNT) begin
      reg_rdata_o <= preamble_byte_count_r;
    end else if (reg_addr_i == ftx_pkg::ADDR_VALIDATION_PREAMBLE_COUNT) begin
      reg_rdata_o <= validation_preamble_count_r;
    end else if (reg_addr_i == ftx_pkg::ADDR_SYNC_PATTERN_LOW_BYTE) begin
      reg_rdata_o <= sync_pattern_low_byte_r;
    end else if (reg_addr_i == ftx_pkg::ADDR_SYNC_PATTERN_MID_BYTE) begin
      reg_rdata_o <= sync_pattern_mid_byte_r;
    end else if (reg_addr_i == ftx_pkg::ADDR_SYNC_PATTERN_HIGH_BYTE) begin
      reg_rdata_o <= sync_pattern_high_byte_r;
    end else if (reg_addr_i == ftx_pkg::ADDR_RADIO_CONFIGURATION) begin
      reg_rdata_o <= operating_select_r;
    end else if (reg_addr_i == ftx_pkg::ADDR_TRANSMIT_BASE_POINTER) begin
      reg_rdata_o <= transmit_base_pointer_r;
    end else if (reg_addr_i == ftx_pkg::ADDR_PKT_CFG) begin
      reg_rdata_o <= {6'h00, pkt_cfg_r};
    end else if (reg_addr_i == ftx_pkg::ADDR_AMP_POWER_LEVEL) begin
      reg_rdata_o <= 8'(amplifier_power_level_r);
    end else if (reg_addr_i == ftx_pkg::ADDR_AMP_BIAS_REGISTER) begin
      reg_rdata_o <= {2'h0, amp_bias_r};
    end else if (reg_addr_i == ftx_pkg::ADDR_AMP_CONFIG_REGISTER) begin
      reg_rdata_o <= {3'h0, bridge_r};
    end else if (reg_addr_i == ftx_pkg::ADDR_STATUS) begin
      reg_rdata_o <= {4'h0, stream_r, sent_flag_r, sfd_flag_r, st_r != ftx_pkg::FTX_IDLE};
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Sticky frame flags, write one to clear, a new event wins
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sfd_flag_r <= 1'b0;
      sent_flag_r <= 1'b0;
    end else begin
      sfd_flag_r <= sfd_evt || (sfd_flag_r && !(wr_status && reg_wdata_i[ftx_pkg::STATUS_SFD_SENT_BIT]));
      sent_flag_r <= sent_evt || (sent_flag_r && !(wr_status && reg_wdata_i[ftx_pkg::STATUS_PKT_SENT_BIT]));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit rate divider with full and half bit enables
  assign bit_en = (div_r == 16'(BIT_DIV - 1));
  assign half_en = (div_r == 16'(BIT_DIV / 2 - 1));
  always_ff @(posedge core_clk_i) begin
    if (rst_i || bit_en) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // Amplifier ramp step divider
  assign ramp_tick = (ramp_div_r == 16'(RAMP_DIV - 1));
  always_ff @(posedge core_clk_i) begin
    if (rst_i || ramp_tick) begin
      ramp_div_r <= 16'h0000;
    end else begin
      ramp_div_r <= ramp_div_r + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: chooses each byte at the end of the previous one
  assign framing = (st_r == ftx_pkg::FTX_PRE) || (st_r == ftx_pkg::FTX_SYNC) ||
                   (st_r == ftx_pkg::FTX_PAY) || (st_r == ftx_pkg::FTX_CRC) ||
                   (st_r == ftx_pkg::FTX_POST1) || (st_r == ftx_pkg::FTX_POST2);
  assign byte_end = framing && bit_en && (bit_cnt_r == 3'h7);

  always_comb begin
    st_nxt = st_r;
    byte_cnt_nxt = byte_cnt_r;
    ld = 1'b0;
    ld_byte = ftx_pkg::PATTERN_ALT;
    fetch = 1'b0;
    crc_upd = 1'b0;
    sfd_evt = 1'b0;
    sent_evt = 1'b0;
    case (st_r)
      ftx_pkg::FTX_IDLE: begin
        if (start_cmd && (operating_select_r == ftx_pkg::OPSEL_PACKET_TX ||
                          operating_select_r == ftx_pkg::OPSEL_SERIAL_TX)) begin
          st_nxt = ftx_pkg::FTX_CAL;
        end
      end
      ftx_pkg::FTX_CAL: begin
        if (tmr_r == 16'(CAL_CYCLES - 1)) begin
          st_nxt = ftx_pkg::FTX_RAMP;
          fetch = !stream_r;
        end
      end
      ftx_pkg::FTX_RAMP: begin
        if (amp_level_o == amplifier_power_level_r && bit_en) begin
          ld = 1'b1;
          if (stream_r) begin
            st_nxt = ftx_pkg::FTX_STREAM;
          end else if (pre_total != 9'h000) begin
            st_nxt = ftx_pkg::FTX_PRE;
            byte_cnt_nxt = pre_total - 9'h001;
          end else begin
            st_nxt = ftx_pkg::FTX_SYNC;
            ld_byte = sync_pattern_high_byte_r;
            byte_cnt_nxt = 9'h001;
          end
        end
      end
      ftx_pkg::FTX_PRE: begin
        if (byte_end) begin
          ld = 1'b1;
          if (byte_cnt_r == 9'h000) begin
            st_nxt = ftx_pkg::FTX_SYNC;
            ld_byte = sync_pattern_high_byte_r;
            byte_cnt_nxt = 9'h001;
          end else begin
            byte_cnt_nxt = byte_cnt_r - 9'h001;
          end
        end
      end
      ftx_pkg::FTX_SYNC: begin
        if (byte_end) begin
          ld = 1'b1;
          if (byte_cnt_r == 9'h001) begin
            ld_byte = sync_pattern_mid_byte_r;
            byte_cnt_nxt = 9'h000;
          end else if (byte_cnt_r == 9'h000 && ld_byte == ftx_pkg::PATTERN_ALT) begin
            ld_byte = sync_pattern_low_byte_r;
            byte_cnt_nxt = 9'h100; // Low byte now on air
          end else begin
            // Length byte follows the sync pattern directly
            st_nxt = ftx_pkg::FTX_PAY;
            ld_byte = mem_byte_r;
            crc_upd = 1'b1;
            fetch = 1'b1;
            sfd_evt = 1'b1;
            byte_cnt_nxt = (mem_byte_r == 8'h00) ? 9'h000 : {1'b0, mem_byte_r} - 9'h001;
          end
        end
      end
      ftx_pkg::FTX_PAY: begin
        if (byte_end) begin
          ld = 1'b1;
          if (byte_cnt_r != 9'h000) begin
            ld_byte = mem_byte_r;
            crc_upd = 1'b1;
            fetch = (byte_cnt_r != 9'h001);
            byte_cnt_nxt = byte_cnt_r - 9'h001;
          end else if (!pkt_cfg_r[ftx_pkg::PKT_CFG_CRC_OFF_BIT]) begin
            st_nxt = ftx_pkg::FTX_CRC;
            ld_byte = crc_r[15:8];
            byte_cnt_nxt = 9'h001;
          end else begin
            st_nxt = ftx_pkg::FTX_POST1;
          end
        end
      end
      ftx_pkg::FTX_CRC: begin
        if (byte_end) begin
          ld = 1'b1;
          if (byte_cnt_r == 9'h001) begin
            ld_byte = crc_r[7:0];
            byte_cnt_nxt = 9'h000;
          end else begin
            st_nxt = ftx_pkg::FTX_POST1;
          end
        end
      end
      ftx_pkg::FTX_POST1: begin
        if (byte_end) begin
          ld = 1'b1;
          st_nxt = ftx_pkg::FTX_POST2;
        end
      end
      ftx_pkg::FTX_POST2: begin
        if (byte_end) begin
          st_nxt = ftx_pkg::FTX_IDLE;
          sent_evt = 1'b1;
        end
      end
      ftx_pkg::FTX_STREAM: begin
        st_nxt = ftx_pkg::FTX_STREAM;
      end
      default: begin
        st_nxt = ftx_pkg::FTX_IDLE;
      end
    endcase
    if (leave_cmd) begin
      st_nxt = ftx_pkg::FTX_IDLE;
      ld = 1'b0;
      fetch = 1'b0;
      sfd_evt = 1'b0;
      sent_evt = 1'b0;
    end
  end

  // State, byte counter, calibration timer and mode latch
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= ftx_pkg::FTX_IDLE;
      byte_cnt_r <= 9'h000;
      tmr_r <= 16'h0000;
      stream_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      tmr_r <= (st_r == ftx_pkg::FTX_CAL) ? tmr_r + 16'h0001 : 16'h0000;
      if (st_r == ftx_pkg::FTX_IDLE && st_nxt == ftx_pkg::FTX_CAL) begin
        stream_r <= (operating_select_r == ftx_pkg::OPSEL_SERIAL_TX);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Packet memory reader, one byte ahead of the serializer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_r <= 8'h00;
      pkt_mem_addr_o <= 8'h00;
      pkt_mem_rd_o <= 1'b0;
      rd_pend_r <= 1'b0;
      mem_byte_r <= 8'h00;
    end else begin
      pkt_mem_rd_o <= fetch;
      rd_pend_r <= pkt_mem_rd_o;
      if (st_r == ftx_pkg::FTX_IDLE) begin
        addr_r <= transmit_base_pointer_r;
      end else if (fetch) begin
        pkt_mem_addr_o <= addr_r;
        addr_r <= addr_r + 8'h01;
      end
      if (rd_pend_r) begin
        mem_byte_r <= pkt_mem_rdata_i;
      end
    end
  end

  // CRC accumulates stored bytes as they go on air
  always_ff @(posedge core_clk_i) begin
    if (rst_i || st_r == ftx_pkg::FTX_IDLE) begin
      crc_r <= CRC_INIT;
    end else if (crc_upd) begin
      crc_r <= crc_byte(crc_r, ld_byte);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Byte serializer, most significant bit first
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shift_r <= ftx_pkg::PATTERN_ALT;
      bit_cnt_r <= 3'h0;
    end else if (ld) begin
      shift_r <= ld_byte;
      bit_cnt_r <= 3'h0;
    end else if (bit_en && framing) begin
      shift_r <= {shift_r[6:0], 1'b0};
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // Serial input synchroniser and shaped-keying delay line
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sp_s1_r <= 1'b0;
      sp_s2_r <= 1'b0;
      sp_d0_r <= 1'b0;
      sp_d1_r <= 1'b0;
    end else begin
      sp_s1_r <= raw_serial_port_data_i;
      sp_s2_r <= sp_s1_r;
      if (bit_en) begin
        sp_d0_r <= sp_s2_r;
        sp_d1_r <= sp_d0_r;
      end
    end
  end

  // Transmit bit and strobe selection
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_data_o <= 1'b0;
      tx_bit_strobe_o <= 1'b0;
      tx_active_o <= 1'b0;
    end else begin
      tx_bit_strobe_o <= bit_en && (framing || st_r == ftx_pkg::FTX_STREAM);
      tx_active_o <= framing || (st_r == ftx_pkg::FTX_STREAM);
      if (st_r == ftx_pkg::FTX_STREAM) begin
        if (!pkt_cfg_r[ftx_pkg::PKT_CFG_UNSHAPED_BIT]) begin
          tx_data_o <= sp_d1_r;
        end else if (half_en) begin
          tx_data_o <= sp_s2_r;
        end
      end else if (framing) begin
        tx_data_o <= shift_r[7];
      end else begin
        tx_data_o <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Amplifier enable and level ramping
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      amp_on_o <= 1'b0;
      amp_level_o <= '0;
    end else if (st_nxt == ftx_pkg::FTX_IDLE || st_r == ftx_pkg::FTX_CAL) begin
      amp_on_o <= (st_r == ftx_pkg::FTX_CAL) && (st_nxt == ftx_pkg::FTX_RAMP);
      amp_level_o <= '0;
    end else if (st_r == ftx_pkg::FTX_POST2) begin
      if (ramp_tick && amp_level_o != '0) begin
        amp_level_o <= amp_level_o - 1'b1;
      end
    end else if (ramp_tick && amp_level_o < amplifier_power_level_r) begin
      amp_level_o <= amp_level_o + 1'b1;
    end else if (st_r != ftx_pkg::FTX_RAMP) begin
      amp_level_o <= amplifier_power_level_r;
    end
  end

  // Bias settings and high-power decode
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      amp_bias_control_o <= ftx_pkg::RST_AMP_BIAS_CONTROL;
      bridge_bias_setting_o <= ftx_pkg::RST_BRIDGE_BIAS_SETTING;
      amp_high_power_o <= 1'b0;
    end else begin
      amp_bias_control_o <= amp_bias_r;
      bridge_bias_setting_o <= bridge_r;
      amp_high_power_o <= (amp_bias_r == ftx_pkg::HP_AMP_BIAS_CONTROL) &&
                          (bridge_r == ftx_pkg::HP_BRIDGE_BIAS_SETTING);
    end
  end

  // Frame event pulses, never from serial streaming
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sfd_sent_o <= 1'b0;
      pkt_sent_o <= 1'b0;
    end else begin
      sfd_sent_o <= sfd_evt;
      pkt_sent_o <= sent_evt;
    end
  end

endmodule

`default_nettype wire

/* hw/ftx_pkg.sv */
// Package for the frequency-shift-keyed transmit framer.
// Holds register offsets, field positions, reset values, commands and fixed patterns.
// Assumes a 10-bit byte-wide register address space.
package ftx_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [9:0] ADDR_PREAMBLE_BYTE_COUNT = 10'h102;
  localparam logic [9:0] ADDR_PKT_CFG = 10'h104;
  localparam logic [9:0] ADDR_AMP_POWER_LEVEL = 10'h105;
  localparam logic [9:0] ADDR_AMP_BIAS_REGISTER = 10'h106;
  localparam logic [9:0] ADDR_AMP_CONFIG_REGISTER = 10'h107;
  localparam logic [9:0] ADDR_COMMAND = 10'h108;
  localparam logic [9:0] ADDR_STATUS = 10'h109;
  localparam logic [9:0] ADDR_SYNC_PATTERN_LOW_BYTE = 10'h10c;
  localparam logic [9:0] ADDR_SYNC_PATTERN_MID_BYTE = 10'h10d;
  localparam logic [9:0] ADDR_SYNC_PATTERN_HIGH_BYTE = 10'h10e;
  localparam logic [9:0] ADDR_RADIO_CONFIGURATION = 10'h13e;
  localparam logic [9:0] ADDR_TRANSMIT_BASE_POINTER = 10'h314;
  localparam logic [9:0] ADDR_VALIDATION_PREAMBLE_COUNT = 10'h3f3;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int PKT_CFG_CRC_OFF_BIT = 0;
  localparam int PKT_CFG_UNSHAPED_BIT = 1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_SFD_SENT_BIT = 1;
  localparam int STATUS_PKT_SENT_BIT = 2;
  localparam int STATUS_STREAM_BIT = 3;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_PREAMBLE_BYTE_COUNT = 8'h03;
  localparam logic [7:0] RST_VALIDATION_PREAMBLE_COUNT = 8'h00;
  localparam logic [7:0] RST_SYNC_BYTE = 8'haa;
  localparam logic [7:0] RST_RADIO_CONFIGURATION = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_BASE_POINTER = 8'h00;
  localparam logic [1:0] RST_PKT_CFG = 2'h0;
  localparam logic [5:0] RST_AMP_BIAS_CONTROL = 6'h00;
  localparam logic [4:0] RST_BRIDGE_BIAS_SETTING = 5'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Operating selects, commands and patterns
  localparam logic [7:0] OPSEL_SERIAL_TX = 8'h03;
  localparam logic [7:0] OPSEL_PACKET_TX = 8'h04;
  localparam logic [7:0] CMD_ENTER_TX = 8'h01;
  localparam logic [7:0] CMD_LEAVE_TX = 8'h02;
  localparam logic [7:0] PATTERN_ALT = 8'haa;
  localparam logic [5:0] HP_AMP_BIAS_CONTROL = 6'h3f;
  localparam logic [4:0] HP_BRIDGE_BIAS_SETTING = 5'h15;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // Framer states
  typedef enum logic [3:0] {
    FTX_IDLE, FTX_CAL, FTX_RAMP, FTX_PRE, FTX_SYNC, FTX_PAY, FTX_CRC,
    FTX_POST1, FTX_POST2, FTX_STREAM
  } ftx_state_e;

endpackage

/* verif/ftx_framer_props.sv */
// Checker on the framer top ports.
// Assumes a bind from the bench top.
`timescale 1ns/1ns
`default_nettype none
module ftx_framer_props (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic pkt_mem_rd_o,
  input wire logic tx_bit_strobe_o,
  input wire logic tx_active_o,
  input wire logic amp_on_o,
  input wire logic [5:0] amp_bias_control_o,
  input wire logic [4:0] bridge_bias_setting_o,
  input wire logic amp_high_power_o,
  input wire logic sfd_sent_o,
  input wire logic pkt_sent_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  // Frame timing and amplifier checks
  a_high_power: assert property (amp_high_power_o ==
    (amp_bias_control_o == 6'h3f && bridge_bias_setting_o == 5'h15)) else $error("hp");
  a_sent_amp_off: assert property (pkt_sent_o |-> ##[0:2] !amp_on_o) else $error("amp");
  a_sfd_pulse: assert property (sfd_sent_o |=> !sfd_sent_o) else $error("sfd");
  a_sent_pulse: assert property (pkt_sent_o |=> !pkt_sent_o) else $error("sent");
  a_bit_gap: assert property (tx_bit_strobe_o |=> !tx_bit_strobe_o[*3]) else $error("gap");
  a_sfd_in_frame: assert property (sfd_sent_o |-> tx_active_o && amp_on_o) else $error("sf");
  a_fetch_pulse: assert property (pkt_mem_rd_o |=> !pkt_mem_rd_o) else $error("rd");
  a_ramp_first: assert property ($rose(tx_active_o) |-> amp_on_o) else $error("ramp");
  c_sfd: cover property (sfd_sent_o);
  c_sent: cover property (pkt_sent_o);
  c_hp: cover property (amp_high_power_o);
endmodule
`default_nettype wire

/* verif/ftx_framer_tb_top.sv */
// Bench: registers, packet frames, serial streaming.
// Assumes package, framer, model and checker compiled first.
`timescale 1ns/1ns
`default_nettype none
module ftx_framer_tb_top;
  logic core_clk_i, rst_i, reg_wr_i, reg_rd_i, ser, mrd, txd, stb, act, amp, hp, sfd, sent;
  logic [9:0] reg_addr_i;
  logic [7:0] reg_wdata_i, rdat, maddr, mdat;
  logic [4:0] lvl;
  logic [7:0] got [$];
  int failures, tests_run, cyc = 0;
  ftx_framer #(.BIT_DIV(4), .CAL_CYCLES(8), .RAMP_DIV(2)) i_dut (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(rdat), .pkt_mem_addr_o(maddr), .pkt_mem_rd_o(mrd),
    .pkt_mem_rdata_i(mdat), .raw_serial_port_data_i(ser), .tx_data_o(txd),
    .tx_bit_strobe_o(stb), .tx_active_o(act), .amp_on_o(amp), .amp_level_o(lvl),
    .amp_bias_control_o(), .bridge_bias_setting_o(), .amp_high_power_o(hp),
    .sfd_sent_o(sfd), .pkt_sent_o(sent));
  ftx_pkt_mem_model i_mem (.core_clk_i(core_clk_i), .rd_i(mrd), .addr_i(maddr), .rdata_o(mdat));
  // Clock and hang limit
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(rdat, e);
    @(posedge core_clk_i);
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
    return c;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic frame(input logic off);
    logic [7:0] exp [$];
    logic [7:0] b;
    logic [15:0] c;
    int nb, ns;
    nb = 0;
    ns = 0;
    got = {};
    exp = {8'haa, 8'haa, 8'h12, 8'h34, 8'h56, 8'h02, 8'h5a};
    c = crc16(16'h025a);
    if (!off) exp = {exp, c[15:8], c[7:0]};
    exp = {exp, 8'haa, 8'haa};
    wr(10'h104, {7'h00, off});
    wr(10'h108, ftx_pkg::CMD_ENTER_TX);
    for (int n = 0; n < 3000 && !sent; n++) begin
      @(posedge core_clk_i);
      #1;
      ns += sfd;
      if (sfd) chk(lvl, 5'h03);
      if (stb) b = {b[6:0], txd};
      if (stb) nb++;
      if (stb && nb % 8 == 0) got.push_back(b);
    end
    chk(ns, 1);
    chk(got.size(), exp.size());
    foreach (exp[i]) chk(got[i], exp[i]);
    // Sticky sync and sent flags, then write one to clear
    rd(10'h109, 8'h06);
    wr(10'h109, 8'h06);
    rd(10'h109, 8'h00);
    $display("frame test done, crc off %0d", off);
  endtask
  task automatic serial();
    int s;
    s = 0;
    wr(10'h13e, ftx_pkg::OPSEL_SERIAL_TX);
    wr(10'h104, 8'h02);
    ser <= 1'b1;
    wr(10'h108, ftx_pkg::CMD_ENTER_TX);
    repeat (300) begin
      @(posedge core_clk_i);
      #1 s += sfd | sent;
    end
    chk({act, txd}, 2'b11);
    chk(s, 0);
    wr(10'h108, ftx_pkg::CMD_LEAVE_TX);
    #1 chk(act, 0);
    $display("serial test done");
  endtask
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, ser} = {1'b1, 21'h0};
    i_mem.mem[8'h10] = 8'h02;
    i_mem.mem[8'h11] = 8'h5a;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(10'h102, 8'h03);
    rd(10'h10e, 8'haa);
    rd(10'h104, 8'h00);
    rd(10'h200, 8'h00);
    wr(10'h106, 8'h3f);
    wr(10'h107, 8'h15);
    @(posedge core_clk_i);
    chk(hp, 1);
    $display("register test done");
    wr(10'h102, 8'h01);
    wr(10'h3f3, 8'h01);
    wr(10'h10e, 8'h12);
    wr(10'h10d, 8'h34);
    wr(10'h10c, 8'h56);
    wr(10'h314, 8'h10);
    wr(10'h105, 8'h03);
    wr(10'h13e, ftx_pkg::OPSEL_PACKET_TX);
    frame(1'b0);
    repeat (4) @(posedge core_clk_i);
    frame(1'b1);
    serial();
    print_verdict();
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule
bind ftx_framer ftx_framer_props i_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .pkt_mem_rd_o(pkt_mem_rd_o), .tx_bit_strobe_o(tx_bit_strobe_o), .tx_active_o(tx_active_o),
  .amp_on_o(amp_on_o), .amp_bias_control_o(amp_bias_control_o),
  .bridge_bias_setting_o(bridge_bias_setting_o), .amp_high_power_o(amp_high_power_o),
  .sfd_sent_o(sfd_sent_o), .pkt_sent_o(pkt_sent_o));
`default_nettype wire

/* verif/ftx_pkt_mem_model.sv */
// Packet memory filled by the host side.
// Assumes one read pulse per byte, answered a cycle later.
`timescale 1ns/1ns
`default_nettype none
module ftx_pkt_mem_model (
  input wire logic core_clk_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [256];
  // Answer a read, else show a changing pattern
  always @(posedge core_clk_i) begin
    if (rd_i) rdata_o <= mem[addr_i];
    else rdata_o <= addr_i ^ 8'h5a;
  end
endmodule
`default_nettype wire
